// >>> rtl/dual_mode_host_port.sv
// host register access port with latch-strobe and transfer-start modes
// assumes all pins are synchronous to i_core_clk, which also serves as the host processor clock;
// the register space answers i_reg_rdata combinationally for o_reg_req.reg_addr
`timescale 1ns/1ps
`include "dual_mode_host_port_regs.svh"

module dual_mode_host_port #(
    parameter logic [`DHP_SEL_W-1:0] DEV_SEL = `DHP_DEV_SEL_DFLT  // this device's select code
) (
    input  wire logic                           i_core_clk,
    input  wire logic                           i_arst_n,
    input  wire logic [`DHP_MODE_W-1:0]         i_bus_mode_select,
    input  wire logic                           i_cs_n,
    input  wire logic [`DHP_ADDR_W-1:0]         i_addr,
    input  wire logic                           i_addr_latch_strobe_pin,
    input  wire logic                           i_rd_n,
    input  wire logic                           i_wr_n,
    input  wire logic [`DHP_DATA_W-1:0]         i_data,
    output logic      [`DHP_DATA_W-1:0]         o_data,
    output logic                                o_data_oe,
    output logic                                o_cycle_done_pin_n,
    output dual_mode_host_port_pkg::reg_req_t   o_reg_req,
    input  wire logic [`DHP_DATA_W-1:0]         i_reg_rdata
);

    localparam int ACK_MAX = `DHP_ACK_MAX_CYC;

    dual_mode_host_port_pkg::bus_mode_t   mode_q;
    dual_mode_host_port_pkg::port_state_t state_q;
    logic [`DHP_ADDR_W-1:0]               addr_q;
    logic                                 strobe_q;
    logic [`DHP_DATA_W-1:0]               data_q;
    logic                                 oe_q;
    logic                                 done_n_q;
    logic                                 is_rd_q;
    logic [`DHP_ADDR_W-1:0]               eff_addr;
    logic                                 strobe_fell;
    logic                                 selected;
    logic                                 start_rd;
    logic                                 start_wr;
    logic                                 release_c;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // strap decode; any unlisted code falls back to latch-strobe
    function automatic dual_mode_host_port_pkg::bus_mode_t decode_mode(input logic [`DHP_MODE_W-1:0] code);
        decode_mode = (code == `DHP_MODE_SYNC) ? dual_mode_host_port_pkg::MODE_TRANSFER_START
                                              : dual_mode_host_port_pkg::MODE_LATCH_STROBE;
    endfunction

    // device select field of an address
    function automatic logic [`DHP_SEL_W-1:0] sel_field(input logic [`DHP_ADDR_W-1:0] a);
        sel_field = a[`DHP_SEL_MSB:`DHP_SEL_LSB];
    endfunction

    // ****************************************************************
    // mode select
    // ****************************************************************

    // straps follow the pins while state_q is ST_IDLE, also on the edge that starts an access, which then releases in the new mode
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= dual_mode_host_port_pkg::MODE_LATCH_STROBE;
        end else if (state_q == dual_mode_host_port_pkg::ST_IDLE) begin
            mode_q <= decode_mode(i_bus_mode_select);
        end
    end

    // ****************************************************************
    // address capture
    // ****************************************************************

    // previous strobe level for falling edge detection
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= i_addr_latch_strobe_pin;
        end
    end

    assign strobe_fell = strobe_q && !i_addr_latch_strobe_pin && !i_cs_n;

    // same pin latches in both modes; only chip select qualifies it
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_q <= `DHP_ADDR_RST;
        end else if (strobe_fell) begin
            addr_q <= i_addr;
        end
    end

    // in latch-strobe mode a latch strobe parked high means the host has none: follow the bus live
    always_comb begin
        if (mode_q == dual_mode_host_port_pkg::MODE_LATCH_STROBE && i_addr_latch_strobe_pin) begin
            eff_addr = i_addr;
        end else begin
            eff_addr = addr_q;
        end
    end

    // ****************************************************************
    // cycle start decode
    // ****************************************************************

    // chip select and the device select field gate every strobe that starts a cycle
    assign selected = !i_cs_n && (sel_field(eff_addr) == DEV_SEL);

    // latch-strobe mode uses separate read and write strobes; transfer-start uses
    // the access strobe with the direction pin, all sampled on the host clock
    always_comb begin
        start_rd = 1'b0;
        start_wr = 1'b0;
        if (state_q == dual_mode_host_port_pkg::ST_IDLE && selected) begin
            if (mode_q == dual_mode_host_port_pkg::MODE_LATCH_STROBE) begin
                start_rd = !i_rd_n;
                start_wr = i_rd_n && !i_wr_n;
            end else begin
                start_rd = !i_rd_n && i_wr_n;
                start_wr = !i_rd_n && !i_wr_n;
            end
        end
    end

    // a cycle closes when its strobe rises or chip select goes away
    always_comb begin
        if (mode_q == dual_mode_host_port_pkg::MODE_LATCH_STROBE && !is_rd_q) begin
            release_c = i_wr_n || i_cs_n;
        end else begin
            release_c = i_rd_n || i_cs_n;
        end
    end

    // ****************************************************************
    // register request
    // ****************************************************************

    // write is a single-cycle strobe so a long host pulse stores the byte once
    always_comb begin
        o_reg_req.wr       = start_wr;
        o_reg_req.reg_addr = eff_addr[`DHP_REG_MSB:0];
        o_reg_req.wdata    = i_data;
    end

    // ****************************************************************
    // cycle state
    // ****************************************************************

    // acknowledge follows the strobe by one cycle, inside the longest allowed time
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= dual_mode_host_port_pkg::ST_IDLE;
        end else begin
            case (state_q)
                dual_mode_host_port_pkg::ST_IDLE: begin
                    if (start_rd || start_wr) begin
                        state_q <= dual_mode_host_port_pkg::ST_ACK;
                    end
                end
                dual_mode_host_port_pkg::ST_ACK: begin
                    if (release_c) begin
                        state_q <= dual_mode_host_port_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= dual_mode_host_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // direction of the open cycle, used to pick the strobe that ends it
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            is_rd_q <= 1'b0;
        end else if (start_rd || start_wr) begin
            is_rd_q <= start_rd;
        end
    end

    // ****************************************************************
    // data bus and completion output
    // ****************************************************************

    // read data is held for the whole cycle, so a register change mid-cycle cannot tear it
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_q <= `DHP_DATA_RST;
        end else if (start_rd) begin
            data_q <= i_reg_rdata;
        end
    end

    // drivers on only during a read, off as soon as the cycle releases
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            oe_q <= 1'b0;
        end else if (start_rd) begin
            oe_q <= 1'b1;
        end else if (state_q == dual_mode_host_port_pkg::ST_ACK && release_c) begin
            oe_q <= 1'b0;
        end
    end

    // completion low from the cycle after the strobe until release
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            done_n_q <= 1'b1;
        end else if (start_rd || start_wr) begin
            done_n_q <= 1'b0;
        end else if (state_q == dual_mode_host_port_pkg::ST_ACK && release_c) begin
            done_n_q <= 1'b1;
        end
    end

    assign o_data             = data_q;
    assign o_data_oe          = oe_q;
    assign o_cycle_done_pin_n = done_n_q;

    // ****************************************************************
    // assertions
    // ****************************************************************

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    sequence rd_taken_s;
        start_rd;
    endsequence

    sequence wr_taken_s;
        start_wr;
    endsequence

    sequence acked_s;
        !o_cycle_done_pin_n;
    endsequence

    addr_latch_a : assert property (
        (strobe_fell && mode_q == dual_mode_host_port_pkg::MODE_LATCH_STROBE) |=> addr_q == $past(i_addr))
        else $error("address not captured on latch strobe fall");

    ts_latch_a : assert property (
        (strobe_fell && mode_q == dual_mode_host_port_pkg::MODE_TRANSFER_START) |=> addr_q == $past(i_addr))
        else $error("address not captured on transfer start fall");

    direct_addr_a : assert property (
        (mode_q == dual_mode_host_port_pkg::MODE_LATCH_STROBE && i_addr_latch_strobe_pin)
        |-> o_reg_req.reg_addr == i_addr[`DHP_REG_MSB:0])
        else $error("live address not used with latch strobe high");

    read_drive_a : assert property (
        rd_taken_s |=> (o_data_oe && o_data == $past(i_reg_rdata)))
        else $error("read data not driven");

    ready_low_a : assert property (
        (rd_taken_s and (mode_q == dual_mode_host_port_pkg::MODE_LATCH_STROBE)) |-> ##[1:ACK_MAX] acked_s)
        else $error("ready late after read strobe");

    write_store_a : assert property (
        wr_taken_s |-> (o_reg_req.wdata == i_data) ##1 (acked_s and !o_data_oe))
        else $error("write not stored then completed");

    sync_ack_a : assert property (
        (rd_taken_s and (mode_q == dual_mode_host_port_pkg::MODE_TRANSFER_START))
        |-> ##[1:ACK_MAX] (acked_s and o_data_oe))
        else $error("transfer acknowledge late or data off");

    bus_release_a : assert property (
        (state_q == dual_mode_host_port_pkg::ST_ACK && release_c) |=> (o_cycle_done_pin_n && !o_data_oe))
        else $error("bus not released at cycle end");

    dev_select_a : assert property (
        o_reg_req.wr |-> (sel_field(eff_addr) == DEV_SEL && !i_cs_n))
        else $error("write outside device select");

    mode_follow_a : assert property (
        (state_q == dual_mode_host_port_pkg::ST_IDLE) |=> mode_q == decode_mode($past(i_bus_mode_select)))
        else $error("mode does not follow select pins");

endmodule

// >>> rtl/dual_mode_host_port_pkg.sv
// types shared by the dual mode host port and its register space
// assumes the constants header is on the include path
`include "dual_mode_host_port_regs.svh"

package dual_mode_host_port_pkg;

    // ****************************************************************
    // bus mode, port state and register request
    // ****************************************************************
    typedef enum logic {
        MODE_LATCH_STROBE,
        MODE_TRANSFER_START
    } bus_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACK
    } port_state_t;

    // one access toward the on-chip register space
    typedef struct packed {
        logic                        wr;
        logic [`DHP_REG_ADDR_W-1:0]  reg_addr;
        logic [`DHP_DATA_W-1:0]      wdata;
    } reg_req_t;

endpackage

// >>> rtl/dual_mode_host_port_regs.svh
// constants of the dual mode host port: widths, field positions, mode codes, timing
// assumes inclusion by bare name from the package and the port module
`ifndef DUAL_MODE_HOST_PORT_REGS_SVH
`define DUAL_MODE_HOST_PORT_REGS_SVH

// ****************************************************************
// bus widths and address fields
// ****************************************************************
`define DHP_ADDR_W       11
`define DHP_REG_ADDR_W   8
`define DHP_DATA_W       8
`define DHP_SEL_W        3
`define DHP_SEL_LSB      8
`define DHP_SEL_MSB      10
`define DHP_REG_MSB      7

// ****************************************************************
// mode select strap codes and reset values
// ****************************************************************
`define DHP_MODE_W       3
`define DHP_MODE_SYNC    3'h1
`define DHP_MODE_RST     3'h0
`define DHP_DEV_SEL_DFLT 3'h0
`define DHP_DATA_RST     8'h00
`define DHP_ADDR_RST     11'h000

// ****************************************************************
// timing: strobe assert to acknowledge, longest time
// ****************************************************************
`define DHP_CLK_PERIOD_NS 100
`define DHP_ACK_MAX_NS    150
`define DHP_ACK_MAX_CYC   ((`DHP_ACK_MAX_NS) / (`DHP_CLK_PERIOD_NS))

`endif

// >>> sim/reg_space_model.sv
// register space behind the host port: 256 bytes, combinational read
// assumes o_reg_req.wr is a one-cycle pulse in the i_core_clk domain
`timescale 1ns/1ps

module reg_space_model (
    input  wire logic                              i_core_clk,
    input  wire dual_mode_host_port_pkg::reg_req_t i_reg_req,
    output logic      [7:0]                        o_reg_rdata
);
    logic [7:0] mem_q [256];

    // store on the write pulse; unwritten bytes read unknown, so stale reads show
    always_ff @(posedge i_core_clk) begin
        if (i_reg_req.wr) begin
            mem_q[i_reg_req.reg_addr] <= i_reg_req.wdata;
        end
    end

    // lower eight address bits pick the byte directly
    assign o_reg_rdata = mem_q[i_reg_req.reg_addr];
endmodule

// >>> sim/testbench.sv
// self-checking bench of the dual mode host port, host cycles driven by tasks
// assumes the register space model and the design package are compiled first
`timescale 1ns/1ps

module testbench;
    logic                              i_core_clk;
    logic                              i_arst_n;
    logic [2:0]                        i_bus_mode_select;
    logic                              i_cs_n;
    logic [10:0]                       i_addr;
    logic                              i_addr_latch_strobe_pin;
    logic                              i_rd_n;
    logic                              i_wr_n;
    logic [7:0]                        i_data;
    logic [7:0]                        o_data;
    logic                              o_data_oe;
    logic                              o_cycle_done_pin_n;
    dual_mode_host_port_pkg::reg_req_t o_reg_req;
    logic [7:0]                        reg_rdata;
    logic                              sync_mode;
    int                                num_errors;
    int                                samples_checked;

    dual_mode_host_port u_dual_mode_host_port (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_bus_mode_select(i_bus_mode_select),
        .i_cs_n(i_cs_n), .i_addr(i_addr), .i_addr_latch_strobe_pin(i_addr_latch_strobe_pin),
        .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
        .o_cycle_done_pin_n(o_cycle_done_pin_n), .o_reg_req(o_reg_req), .i_reg_rdata(reg_rdata)
    );

    reg_space_model u_reg_space_model (
        .i_core_clk(i_core_clk), .i_reg_req(o_reg_req), .o_reg_rdata(reg_rdata)
    );

    // ****************************************************************
    // clock, closing and comparison
    // ****************************************************************
    // 100 ns period
    initial i_core_clk = 1'b0;
    always #50 i_core_clk = ~i_core_clk;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ****************************************************************
    // host cycle: optional latch pulse, strobe, wait ack, release
    // ****************************************************************
    task automatic access(input logic rd, input logic [10:0] a, input logic [7:0] d, input logic pulse);
        int n;
        @(negedge i_core_clk);
        i_cs_n = 1'b0;
        i_addr = a;
        if (pulse) begin
            i_addr_latch_strobe_pin = 1'b1;
            @(negedge i_core_clk);
            i_addr_latch_strobe_pin = 1'b0;
            @(negedge i_core_clk);
            // bus moves on: only the latched copy may select the register
            i_addr = {a[10:8], ~a[7:0]};
        end
        // data and direction settle a cycle ahead of the strobe, which also keeps chip select lead time
        i_data = rd ? ~d : d;
        i_wr_n = sync_mode ? rd : 1'b1;
        @(negedge i_core_clk);
        i_wr_n = rd;
        i_rd_n = sync_mode ? 1'b0 : ~rd;
        n = 0;
        while (o_cycle_done_pin_n !== 1'b0 && n < 6) begin
            @(negedge i_core_clk);
            n++;
        end
        chk(8'(n), 8'h01);
        chk({7'h00, o_data_oe}, {7'h00, rd});
        if (rd) begin
            chk(o_data, d);
        end
        @(negedge i_core_clk);
        i_rd_n = 1'b1;
        i_wr_n = 1'b1;
        i_data = ~i_data;
        @(negedge i_core_clk);
        chk({7'h00, o_cycle_done_pin_n}, 8'h01);
        @(negedge i_core_clk);
        chk({7'h00, o_cycle_done_pin_n, o_data_oe}, 8'h02);
        i_cs_n = 1'b1;
        i_addr_latch_strobe_pin = 1'b1;
    endtask

    task automatic set_mode(input logic [2:0] m);
        @(negedge i_core_clk);
        i_bus_mode_select = m;
        sync_mode = (m == 3'h1);
        repeat (2) @(negedge i_core_clk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // strobe held high: live address, boundary registers
    task automatic t_latch_live;
        set_mode(3'h0);
        access(1'b0, 11'h000, 8'hA1, 1'b0);
        access(1'b0, 11'h0FF, 8'h3E, 1'b0);
        access(1'b1, 11'h000, 8'hA1, 1'b0);
        access(1'b1, 11'h0FF, 8'h3E, 1'b0);
        $display("test latch_live done");
    endtask

    // falling latch strobe captures the address, any non-sync code means latch mode
    task automatic t_latch_event;
        set_mode(3'h5);
        access(1'b0, 11'h0C3, 8'h11, 1'b0);
        access(1'b0, 11'h03C, 8'h77, 1'b1);
        access(1'b1, 11'h0C3, 8'h11, 1'b0);
        access(1'b1, 11'h03C, 8'h77, 1'b1);
        $display("test latch_event done");
    endtask

    // strobes without chip select or with another device code change nothing
    task automatic t_ignore;
        @(negedge i_core_clk);
        i_rd_n = 1'b0;
        repeat (4) begin
            @(negedge i_core_clk);
            chk({7'h00, o_cycle_done_pin_n, o_data_oe}, 8'h02);
        end
        i_rd_n = 1'b1;
        i_cs_n = 1'b0;
        i_addr = 11'h500;
        i_data = 8'hEE;
        i_wr_n = 1'b0;
        repeat (4) begin
            @(negedge i_core_clk);
            chk({7'h00, o_cycle_done_pin_n, o_data_oe}, 8'h02);
        end
        i_wr_n = 1'b1;
        i_cs_n = 1'b1;
        access(1'b1, 11'h000, 8'hA1, 1'b0);
        $display("test ignore done");
    endtask

    // clocked mode: transfer start latches, direction picks read or write
    task automatic t_sync;
        set_mode(3'h1);
        access(1'b0, 11'h0A5, 8'h5C, 1'b1);
        access(1'b0, 11'h001, 8'hC3, 1'b1);
        access(1'b1, 11'h0A5, 8'h5C, 1'b1);
        access(1'b1, 11'h001, 8'hC3, 1'b1);
        $display("test sync done");
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    // all inputs known at time zero, reset held ten cycles
    initial begin
        num_errors = 0;
        samples_checked = 0;
        sync_mode = 1'b0;
        i_arst_n = 1'b0;
        i_bus_mode_select = 3'h0;
        i_cs_n = 1'b1;
        i_addr = 11'h000;
        i_addr_latch_strobe_pin = 1'b1;
        i_rd_n = 1'b1;
        i_wr_n = 1'b1;
        i_data = 8'h00;
        repeat (10) @(negedge i_core_clk);
        i_arst_n = 1'b1;
        repeat (2) @(negedge i_core_clk);
        t_latch_live();
        t_latch_event();
        t_ignore();
        t_sync();
        finish_test();
    end

    // tests need about 120 cycles; almost seventeen times that means a hang
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule
